// [pkg/pps_pkg.sv]
// Shared constants and types for the port pin state controller
package pps_pkg;

  // Operating state of the chip as seen by the pins
  typedef enum logic [1:0] {
    PM_NORMAL,
    PM_SLEEP,
    PM_SWSTBY,
    PM_HWSTBY
  } pps_mode_t;

  // Chip operating modes as strapped
  localparam logic [1:0] MCU_EXP_NOROM = 2'h1;
  localparam logic [1:0] MCU_EXP_ROM   = 2'h2;
  localparam logic [1:0] MCU_SINGLE    = 2'h3;

  // Pin counts
  localparam int ADDR_PINS = 16;
  localparam int GP_PINS   = 8;

  // Pin levels
  localparam logic LVL_LOW  = 1'h0;
  localparam logic LVL_HIGH = 1'h1;

endpackage : pps_pkg

// [hdl/pps_pin_cell.sv]
// One port pin: direction, level and pull-up per operating state
`timescale 1ns/1ns
module pps_pin_cell #(
  parameter bit IS_ADDR = 1'b0
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Operating state taking effect at the next edge
  input  wire pps_pkg::pps_mode_t mode_next,
  input  wire logic [1:0]        mcu_mode,
  // Port control bits
  input  wire logic              ddr,
  input  wire logic              port_output_level_bit,
  // Peripheral takeover
  input  wire logic              periph_en,
  input  wire logic              periph_out,
  input  wire logic              periph_oe,
  // Address bit for address pins
  input  wire logic              addr_bit,
  // Pin drive
  output logic                   pin_out,
  output logic                   pin_oe,
  output logic                   pin_pullup
);

  logic out_reg;
  logic out_next;
  logic oe_reg;
  logic oe_next;
  logic pu_reg;
  logic pu_next;

  always_comb
  begin
    out_next = out_reg;
    oe_next  = oe_reg;
    unique case (mode_next)
      pps_pkg::PM_HWSTBY:
      begin
        out_next = pps_pkg::LVL_LOW;
        oe_next  = 1'b0;
      end
      pps_pkg::PM_SWSTBY:
      begin
        if (IS_ADDR && mcu_mode == pps_pkg::MCU_EXP_NOROM)
        begin
          out_next = pps_pkg::LVL_LOW;
          oe_next  = 1'b1;
        end
        else if (IS_ADDR && mcu_mode == pps_pkg::MCU_EXP_ROM)
        begin
          if (ddr)
          begin
            out_next = pps_pkg::LVL_LOW;
            oe_next  = 1'b1;
          end
        end
        else if (!IS_ADDR)
        begin
          out_next = port_output_level_bit;
          oe_next  = ddr;
        end
      end
      pps_pkg::PM_SLEEP:
      begin
        out_next = out_reg;
        oe_next  = oe_reg;
      end
      pps_pkg::PM_NORMAL:
      begin
        if (IS_ADDR && mcu_mode == pps_pkg::MCU_EXP_NOROM)
        begin
          out_next = addr_bit;
          oe_next  = 1'b1;
        end
        else if (IS_ADDR && mcu_mode == pps_pkg::MCU_EXP_ROM)
        begin
          out_next = ddr & addr_bit;
          oe_next  = ddr;
        end
        else if (periph_en)
        begin
          out_next = periph_out;
          oe_next  = periph_oe;
        end
        else
        begin
          out_next = port_output_level_bit;
          oe_next  = ddr;
        end
      end
    endcase
    pu_next = (mode_next == pps_pkg::PM_SLEEP || mode_next == pps_pkg::PM_SWSTBY)
              && !oe_next && !ddr && port_output_level_bit;
  end

  // Reset floats the pin; address drive waits for the first normal cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      out_reg <= pps_pkg::LVL_LOW;
      oe_reg  <= 1'b0;
      pu_reg  <= 1'b0;
    end
    else
    begin
      out_reg <= out_next;
      oe_reg  <= oe_next;
      pu_reg  <= pu_next;
    end
  end

  assign pin_out    = out_reg;
  assign pin_oe     = oe_reg;
  assign pin_pullup = pu_reg;

endmodule : pps_pin_cell

// [hdl/pps_port_ctrl.sv]
// Port pin state controller: operating state tracking and all pin drive
`timescale 1ns/1ns
// How it works
// - Hardware standby floats every pin, clock pin included, in every mode.
// - Single-chip software standby: clock pin high if direction 1, floating if 0.
// - Single-chip normal: clock pin outputs clock if direction 1, else input.
// - Held input pins float, pull-up on only when direction 0 and level 1.
// - Held output pins keep driving their level from before sleep; in software standby only address pins hold, single-chip or direction 0 in ROM mode.
// - Software standby drops peripherals; general pins follow direction and level bits.
// - General pins take direction from their bit unless a peripheral owns them.
module pps_port_ctrl #(
  parameter int ADDR_W = pps_pkg::ADDR_PINS,
  parameter int GP_W   = pps_pkg::GP_PINS
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // Operating state requests and strap
  input  wire logic                   hw_standby,
  input  wire logic                   sw_standby,
  input  wire logic                   sleep_req,
  input  wire logic [1:0]             mcu_mode,
  // Port control bits, address pins low
  input  wire logic [ADDR_W+GP_W-1:0] ddr,
  input  wire logic [ADDR_W+GP_W-1:0] port_output_level_bit,
  input  wire logic [ADDR_W+GP_W-1:0] periph_en,
  input  wire logic [ADDR_W+GP_W-1:0] periph_out,
  input  wire logic [ADDR_W+GP_W-1:0] periph_oe,
  input  wire logic [ADDR_W-1:0]      addr_bus,
  // Port pins
  input  wire logic [ADDR_W+GP_W-1:0] pin_in,
  output logic      [ADDR_W+GP_W-1:0] pin_out,
  output logic      [ADDR_W+GP_W-1:0] pin_oe,
  output logic      [ADDR_W+GP_W-1:0] pin_pullup,
  output logic      [ADDR_W+GP_W-1:0] port_read,
  // Clock output pin
  input  wire logic                   clk_ddr,
  output logic                        clock_output_pin_o,
  output logic                        clock_output_pin_oe,
  // Current operating state
  output pps_pkg::pps_mode_t          mode_state
);

  localparam int NPIN = ADDR_W + GP_W;

  pps_pkg::pps_mode_t mode_reg;
  pps_pkg::pps_mode_t mode_next;
  logic               ck_sel_reg;
  logic               ck_sel_next;
  logic               ck_oe_reg;
  logic               ck_oe_next;
  logic [NPIN-1:0]    rd_reg;
  logic               live_reg;

  // Expanded modes always own the clock pin; only single-chip mode asks its direction bit
  function automatic logic clock_pin_on(logic [1:0] strap, logic dir);
    return (strap == pps_pkg::MCU_SINGLE) ? dir : 1'b1;
  endfunction : clock_pin_on

  // Standby outranks sleep so a late sleep request cannot hold pins driven
  always_comb
  begin
    if (hw_standby)
      mode_next = pps_pkg::PM_HWSTBY;
    else if (sw_standby)
      mode_next = pps_pkg::PM_SWSTBY;
    else if (sleep_req)
      mode_next = pps_pkg::PM_SLEEP;
    else
      mode_next = pps_pkg::PM_NORMAL;
  end

  always_comb
  begin
    ck_sel_next = 1'b0;
    ck_oe_next  = 1'b0;
    unique case (mode_next)
      pps_pkg::PM_HWSTBY:
      begin
        ck_sel_next = 1'b0;
        ck_oe_next  = 1'b0;
      end
      pps_pkg::PM_SWSTBY:
      begin
        ck_sel_next = 1'b0;
        ck_oe_next  = clock_pin_on(mcu_mode, clk_ddr);
      end
      pps_pkg::PM_SLEEP, pps_pkg::PM_NORMAL:
      begin
        ck_sel_next = clock_pin_on(mcu_mode, clk_ddr);
        ck_oe_next  = ck_sel_next;
      end
    endcase
  end

  // State and pins share one edge
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      mode_reg   <= pps_pkg::PM_NORMAL;
      ck_sel_reg <= 1'b0;
      ck_oe_reg  <= 1'b0;
      rd_reg     <= '0;
      live_reg   <= 1'b0;
    end
    else
    begin
      mode_reg   <= mode_next;
      ck_sel_reg <= ck_sel_next;
      ck_oe_reg  <= ck_oe_next;
      rd_reg     <= pin_in;
      live_reg   <= 1'b1;
    end
  end

  // Clock is passed through a mux; glitch-free only as far as the mux is
  assign clock_output_pin_o  = ck_sel_reg ? clk : pps_pkg::LVL_HIGH;
  assign clock_output_pin_oe = ck_oe_reg;
  assign port_read           = rd_reg;
  assign mode_state          = mode_reg;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pin
      pps_pin_cell #(
        .IS_ADDR (gi < ADDR_W)
      ) u_cell (
        .clk                   (clk),
        .nrst                  (nrst),
        .mode_next             (mode_next),
        .mcu_mode              (mcu_mode),
        .ddr                   (ddr[gi]),
        .port_output_level_bit (port_output_level_bit[gi]),
        .periph_en             (periph_en[gi]),
        .periph_out            (periph_out[gi]),
        .periph_oe             (periph_oe[gi]),
        .addr_bit              ((gi < ADDR_W) ? addr_bus[gi % ADDR_W] : 1'b0),
        .pin_out               (pin_out[gi]),
        .pin_oe                (pin_oe[gi]),
        .pin_pullup            (pin_pullup[gi])
      );
    end
  endgenerate

  // Checks; live_reg keeps $past away from the reset cycle
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_hw_req;
    hw_standby;
  endsequence

  sequence s_all_float;
    mode_reg == pps_pkg::PM_HWSTBY && pin_oe == '0 && !clock_output_pin_oe;
  endsequence

  AST_HW_FLOAT: assert property (live_reg && mode_reg == pps_pkg::PM_HWSTBY |->
    pin_oe == '0 && !clock_output_pin_oe && pin_pullup == '0)
    else $error("pin driven in hardware standby");

  AST_SW_CLOCK_PIN: assert property (live_reg && mode_reg == pps_pkg::PM_SWSTBY
    && $past(mcu_mode) == pps_pkg::MCU_SINGLE |->
    clock_output_pin_oe == $past(clk_ddr) && !ck_sel_reg)
    else $error("clock pin wrong in software standby");

  AST_SW_CLOCK_HIGH: assert property (live_reg && mode_reg == pps_pkg::PM_SWSTBY
    && clock_output_pin_oe |-> clock_output_pin_o == pps_pkg::LVL_HIGH)
    else $error("clock pin not high in software standby");

  AST_RUN_CLOCK_PIN: assert property (live_reg && mode_reg == pps_pkg::PM_NORMAL
    && $past(mcu_mode) == pps_pkg::MCU_SINGLE |->
    ck_sel_reg == $past(clk_ddr) && clock_output_pin_oe == $past(clk_ddr))
    else $error("clock pin wrong in normal operation");

  AST_ADDR_OR_INPUT: assert property (live_reg && mode_reg == pps_pkg::PM_NORMAL
    && $past(mcu_mode) == pps_pkg::MCU_EXP_ROM |->
    pin_oe[ADDR_W-1:0] == $past(ddr[ADDR_W-1:0])
    && pin_out[ADDR_W-1:0] == ($past(addr_bus) & $past(ddr[ADDR_W-1:0])))
    else $error("address pin direction wrong");

  AST_HELD_PULLUP: assert property (live_reg
    && (mode_reg == pps_pkg::PM_SLEEP || mode_reg == pps_pkg::PM_SWSTBY) |->
    pin_pullup == (~pin_oe & ~$past(ddr) & $past(port_output_level_bit)))
    else $error("pull-up wrong on held input");

  AST_NO_PULLUP_ACTIVE: assert property (live_reg
    && (mode_reg == pps_pkg::PM_NORMAL || mode_reg == pps_pkg::PM_HWSTBY) |->
    pin_pullup == '0)
    else $error("pull-up on outside held states");

  AST_SLEEP_HOLD: assert property (live_reg && mode_reg == pps_pkg::PM_SLEEP
    && $past(mode_reg) == pps_pkg::PM_SLEEP |-> $stable(pin_out) && $stable(pin_oe))
    else $error("held pin changed in sleep");

  AST_SLEEP_ENTRY: assert property (live_reg && mode_reg == pps_pkg::PM_SLEEP
    && $past(mode_reg) != pps_pkg::PM_SLEEP |-> $stable(pin_out) && $stable(pin_oe))
    else $error("pin changed on sleep entry");

  AST_SW_ADDR_HOLD: assert property (live_reg && mode_reg == pps_pkg::PM_SWSTBY
    && $past(mcu_mode) == pps_pkg::MCU_SINGLE |->
    $stable(pin_out[ADDR_W-1:0]) && $stable(pin_oe[ADDR_W-1:0]))
    else $error("address pin changed in single-chip software standby");

  AST_SW_REVERT: assert property (live_reg && mode_reg == pps_pkg::PM_SWSTBY |->
    pin_oe[NPIN-1:ADDR_W] == $past(ddr[NPIN-1:ADDR_W])
    && pin_out[NPIN-1:ADDR_W] == $past(port_output_level_bit[NPIN-1:ADDR_W]))
    else $error("port pin not reverted in software standby");

  AST_GP_DIRECTION: assert property (live_reg && mode_reg == pps_pkg::PM_NORMAL |->
    pin_oe[NPIN-1:ADDR_W] == (($past(periph_en[NPIN-1:ADDR_W]) & $past(periph_oe[NPIN-1:ADDR_W]))
    | (~$past(periph_en[NPIN-1:ADDR_W]) & $past(ddr[NPIN-1:ADDR_W]))))
    else $error("port pin direction wrong");

  AST_SAME_EDGE: assert property (s_hw_req |=> s_all_float)
    else $error("pins lag the state change");

endmodule : pps_port_ctrl

// [dv/pps_board_model.sv]
// Board-side model of the port pins
`timescale 1ns/1ns
module pps_board_model #(
  parameter int N = 24
) (
  // Clock
  input  wire logic         clk,
  // Pin drive from the chip
  input  wire logic [N-1:0] pin_out,
  input  wire logic [N-1:0] pin_oe,
  input  wire logic [N-1:0] pin_pullup,
  // Levels seen at the pads
  output logic      [N-1:0] pin_in
);
  logic [N-1:0] ext_reg;
  logic [N-1:0] ext_next;

  // Undriven lines without pull-up wander every cycle so a stale level is never read as valid
  always_comb ext_next = ~ext_reg ^ (ext_reg << 1);
  // Seeded at time zero and stepped on each rising edge, from this one process only
  initial
  begin
    ext_reg = '0;
    forever @(posedge clk) ext_reg <= ext_next;
  end

  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_pullup) | (~pin_oe & ~pin_pullup & ext_reg);
endmodule : pps_board_model

// [dv/port_pin_state_control_test.sv]
// Self-checking bench for the port pin state controller
`timescale 1ns/1ns
`define CHK(nm, ex, gt) \
  begin \
    n_tests++; \
    if ((gt) !== (ex)) \
    begin \
      fail_count++; \
      $display("unexpected %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module port_pin_state_control_test;
  localparam int NP = pps_pkg::ADDR_PINS + pps_pkg::GP_PINS;
  localparam int AW = pps_pkg::ADDR_PINS;
  logic               clk, nrst, hw_standby, sw_standby, sleep_req, clk_ddr, clk_o, clk_oe;
  logic               e_coe, e_csel, armed;
  logic [1:0]         mcu_mode;
  logic [NP-1:0]      ddr, dat, pen, pout, poe, pin_in, pin_out, pin_oe, pin_pullup, port_read;
  logic [NP-1:0]      e_oe, e_out, e_pu, e_rd;
  logic [AW-1:0]      addr_bus;
  pps_pkg::pps_mode_t mode_state, e_mode, m;
  int                 fail_count, n_tests, cyc;

  pps_port_ctrl pps_port_ctrl_inst (.clk(clk), .nrst(nrst), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .sleep_req(sleep_req), .mcu_mode(mcu_mode), .ddr(ddr),
    .port_output_level_bit(dat), .periph_en(pen), .periph_out(pout), .periph_oe(poe),
    .addr_bus(addr_bus), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .port_read(port_read), .clk_ddr(clk_ddr),
    .clock_output_pin_o(clk_o), .clock_output_pin_oe(clk_oe), .mode_state(mode_state));
  pps_board_model #(.N(NP)) pps_board_model_inst (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .pin_in(pin_in));

  function automatic void predict();
    m = hw_standby ? pps_pkg::PM_HWSTBY : sw_standby ? pps_pkg::PM_SWSTBY :
        sleep_req ? pps_pkg::PM_SLEEP : pps_pkg::PM_NORMAL;
    e_rd = nrst ? pin_in : '0;
    if (!nrst)
      m = pps_pkg::PM_HWSTBY;
    for (int i = 0; i < NP; i++)
    begin
      if (m == pps_pkg::PM_HWSTBY)
        e_oe[i] = 1'h0;
      else if (m == pps_pkg::PM_SLEEP || (m == pps_pkg::PM_SWSTBY && i < AW &&
               (mcu_mode == pps_pkg::MCU_SINGLE || (mcu_mode == pps_pkg::MCU_EXP_ROM && !ddr[i]))))
        e_oe[i] = e_oe[i];
      else if (m == pps_pkg::PM_SWSTBY && i < AW)
        {e_oe[i], e_out[i]} = 2'h2;
      else if (m == pps_pkg::PM_NORMAL && i < AW && mcu_mode != pps_pkg::MCU_SINGLE)
        {e_oe[i], e_out[i]} = {mcu_mode == pps_pkg::MCU_EXP_NOROM || ddr[i], addr_bus[i]};
      else if (m == pps_pkg::PM_NORMAL && pen[i])
        {e_oe[i], e_out[i]} = {poe[i], pout[i]};
      else
        {e_oe[i], e_out[i]} = {ddr[i], dat[i]};
      e_pu[i] = (m == pps_pkg::PM_SLEEP || m == pps_pkg::PM_SWSTBY) && !e_oe[i] && !ddr[i] && dat[i];
    end
    e_coe = nrst && m != pps_pkg::PM_HWSTBY && (mcu_mode != pps_pkg::MCU_SINGLE || clk_ddr);
    e_csel = e_coe && m != pps_pkg::PM_SWSTBY;
    e_mode = nrst ? m : pps_pkg::PM_NORMAL;
  endfunction : predict

  task automatic step(logic h, logic s, logic l, logic [1:0] mm, logic rs);
    @(negedge clk);
    #1;
    if (armed)
    begin
      `CHK("pin_oe", e_oe, pin_oe)
      `CHK("pin_out", e_out & e_oe, pin_out & e_oe)
      `CHK("pin_pullup", e_pu, pin_pullup)
      `CHK("clock_oe", e_coe, clk_oe)
      `CHK("clock_out", ~e_csel, clk_o)
      `CHK("mode_state", e_mode, mode_state)
      `CHK("port_read", e_rd, port_read)
    end
    {hw_standby, sw_standby, sleep_req, mcu_mode, nrst} = {h, s, l, mm, rs};
    {ddr, dat, pen, pout, poe} = {NP'($urandom), NP'($urandom), NP'($urandom),
                                  NP'($urandom), NP'($urandom)};
    addr_bus = AW'($urandom);
    clk_ddr = 1'($urandom);
    predict();
    armed = 1'h1;
  endtask : step

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // Run is about 2100 cycles; the ceiling leaves ample margin
  always @(posedge clk)
  begin
    cyc++;
    if (cyc >= 4000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  initial
  begin
    void'($urandom(32'h8468362d));
    {armed, nrst, hw_standby, sw_standby, sleep_req, clk_ddr} = '0;
    {mcu_mode, ddr, dat, pen, pout, poe, addr_bus} = '0;
    {e_oe, e_out, e_pu, e_rd} = '0;
    repeat (20) step(0, 0, 0, 2'h3, 0);
    for (int mm = 1; mm < 4; mm++)
    begin
      repeat (6) step(0, 0, 0, 2'(mm), 1);
      repeat (4) step(0, 0, 1, 2'(mm), 1);
      repeat (4) step(0, 1, 0, 2'(mm), 1);
      step(0, 1, 1, 2'(mm), 1);
      step(1, 1, 1, 2'(mm), 1);
      step(1, 0, 0, 2'(mm), 1);
      repeat (3) step(0, 0, 0, 2'(mm), 1);
    end
    // Reset in mid-run
    repeat (3) step(0, 0, 0, 2'h2, 0);
    repeat (2000) step(($urandom % 8) == 0, ($urandom % 6) == 0, ($urandom % 5) == 0,
                       2'(1 + $urandom % 3), ($urandom % 200) != 0);
    report_and_stop();
  end
endmodule : port_pin_state_control_test
